// ===== nce_defs.svh
// constants for the nibble core instruction executor
`ifndef NCE_DEFS_SVH
`define NCE_DEFS_SVH
// ------------------------------------------------------------
// instruction word fields
// ------------------------------------------------------------
`define NCE_CLS_HI        9
`define NCE_CLS_LO        6
`define NCE_LO_HI         3
`define NCE_MEM_HI        5
`define NCE_CLS_MISC      4'h0
`define NCE_CLS_COPY_ACC_TO_SYSREG      4'h1
`define NCE_CLS_COPY_SYSREG_TO_ACC      4'h2
`define NCE_CLS_SKIP_IF_ACC_EQUALS_LITERAL      4'h3
`define NCE_CLS_SKIP_IF_ACC_EQUALS_MEM      4'h4
`define NCE_CLS_SKIP_IF_MEM_ZERO      4'h5
`define NCE_CLS_JMP       4'h6
`define NCE_CLS_CALL      4'h7
`define NCE_M_NOP         4'h0
`define NCE_M_CLR_CARRY   4'h1
`define NCE_M_SET_CARRY   4'h2
`define NCE_M_INC_ACC     4'h3
`define NCE_M_DEC_ACC     4'h4
`define NCE_M_SKIP_NC     4'h5
`define NCE_M_SKIP_NZ     4'h6
`define NCE_M_CLK_SEL     4'h7
`define NCE_M_TMR_LOAD    4'h8
`define NCE_M_TMR_READ    4'h9
`define NCE_M_INT_RET     4'hA
`define NCE_M_PC_READ     4'hB
`define NCE_M_HALT        4'hC
`define NCE_M_IND_JMP     4'hD
`define NCE_M_TBL_READ    3'h7
// ------------------------------------------------------------
// reset value, interrupt vector, arithmetic steps, register offsets
// ------------------------------------------------------------
`define NCE_RESET_PC      10'h000
`define NCE_INT_VECTOR    10'h004
`define NCE_SYSREG_PAGE   4'hF
`define NCE_INC_STEP      5'h01
`define NCE_DEC_STEP      5'h0F
`define NCE_PC_STEP       10'h001
`define NCE_APB_CTRL      12'h000
`define NCE_APB_STATUS    12'h004
`define NCE_APB_POINTER   12'h008
`endif

// ===== nce_pkg.sv
// types shared by the nibble core instruction executor
package nce_pkg;
	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_EXEC    = 7'h01,
		ST_WORD2   = 7'h02,
		ST_TBL_RD  = 7'h04,
		ST_TBL_END = 7'h08,
		ST_XTRA    = 7'h10,
		ST_HALT    = 7'h20,
		ST_SKIP2   = 7'h40
	} nce_state_t;
	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic       we;
		logic [3:0] addr;
		logic [3:0] data;
	} nce_sysw_t;
	typedef struct packed {
		logic       load;
		logic [7:0] count;
	} nce_timer_t;
	typedef struct packed {
		logic [9:0] pc;
		logic [3:0] acc;
		logic       page;
		logic       carry;
		logic       zero;
	} nce_save_t;
	typedef struct packed {
		logic [29:0] rsvd;
		logic        wake;
		logic        int_en;
	} nce_ctrl_t;
	typedef struct packed {
		logic [13:0] rsvd;
		logic        in_isr;
		logic        halted;
		logic        zero;
		logic        carry;
		logic [3:0]  acc;
		logic [9:0]  pc;
	} nce_status_t;
	typedef struct packed {
		logic [15:0] rsvd;
		logic [1:0]  top;
		logic [3:0]  high;
		logic [9:0]  ptr;
	} nce_ptr_rd_t;
endpackage

// ===== nce_core.sv
// nibble core executor: moves, flags, skips, carrier timer, jumps, table read, halt
//
// Contract
// RULE1: accumulator copied to addressed system register
// RULE2: system register to accumulator, zero updated
// RULE3: carry forced clear or set, one cycle
// RULE4: accumulator plus one, carry and zero
// RULE5: accumulator minus one, carry and zero
// RULE6: skip next when accumulator equals RAM
// RULE7: skip next when RAM nibble zero
// RULE8: skip on literal match, whole two-word
// RULE9: skip next when carry clear
// RULE10: skip next when zero flag clear
// RULE11: low accumulator bits to carrier clock select
// RULE12: pointer low byte loads carrier timer
// RULE13: carrier timer count into pointer
// RULE14: direct jump, two words, two cycles
// RULE15: call saves address plus two, jumps
// RULE16: three-cycle table read, optional pointer step
// RULE17: interrupt return restores pc and state
// RULE18: pc plus one into pointer, two cycles
// RULE19: halt stops system clock in one cycle
// RULE20: indirect jump from pointer, two cycles
// RULE21: no-op changes nothing, one cycle
// RULE22: accumulator is four bits wide
// RULE23: carrier clock select is two bits
// RULE24: own encoding; skip drops both words
// RULE25: stay halted until wake, then continue
`include "nce_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module nce_core (
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              reset_i,
	// program rom, asynchronous read
	output logic [9:0]             rom_addr_o,
	input  wire logic [9:0]        rom_data_i,
	// ram and system register read ports
	output logic [5:0]             ram_addr_o,
	input  wire logic [3:0]        ram_data_i,
	output logic [3:0]             sysreg_raddr_o,
	input  wire logic [3:0]        sysreg_rdata_i,
	// system register write, carrier timer
	output var nce_pkg::nce_sysw_t sysw_o,
	output var nce_pkg::nce_timer_t timer_o,
	output logic [1:0]             clk_sel_o,
	input  wire logic [7:0]        timer_count_i,
	// interrupt, wake and clock control
	input  wire logic              int_req_i,
	input  wire logic              wake_i,
	output logic                   clock_run_o,
	// apb slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [11:0]       paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o
);
	import nce_pkg::*;

	function automatic logic [9:0] nce_inc(input logic [9:0] v);
		return v + `NCE_PC_STEP;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	nce_state_t  state, next_state;
	logic [9:0]  pc, next_pc;
	logic [9:0]  rom_addr, next_rom_addr;
	logic [3:0]  acc, next_acc;
	logic        carry, next_carry;
	logic        zero, next_zero;
	logic        page, next_page;
	logic [9:0]  ptr, next_ptr;
	logic [3:0]  rom_high, next_rom_high;
	logic [1:0]  rom_top, next_rom_top;
	logic [1:0]  clk_sel, next_clk_sel;
	nce_timer_t  timer, next_timer;
	nce_sysw_t   sysw, next_sysw;
	logic [9:0]  hold, next_hold;
	logic        skip_pending, next_skip;
	logic        in_isr, next_in_isr;
	nce_save_t   save, next_save;
	logic        clock_run, next_run;
	logic        wake_meta, wake_sync;
	logic        int_en, apb_wake;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire [9:0] instr   = rom_data_i;
	wire [3:0] op_cls  = instr[`NCE_CLS_HI:`NCE_CLS_LO];
	wire [3:0] op_lo   = instr[`NCE_LO_HI:0];
	wire       is_misc = op_cls == `NCE_CLS_MISC;
	wire d_copy_acc_to_sysreg   = op_cls == `NCE_CLS_COPY_ACC_TO_SYSREG;
	wire d_copy_sysreg_to_acc   = op_cls == `NCE_CLS_COPY_SYSREG_TO_ACC;
	wire d_skip_if_acc_equals_literal   = op_cls == `NCE_CLS_SKIP_IF_ACC_EQUALS_LITERAL;
	wire d_skip_if_acc_equals_mem   = op_cls == `NCE_CLS_SKIP_IF_ACC_EQUALS_MEM;
	wire d_skip_if_mem_zero   = op_cls == `NCE_CLS_SKIP_IF_MEM_ZERO;
	wire d_jmp    = op_cls == `NCE_CLS_JMP;
	wire d_call   = op_cls == `NCE_CLS_CALL;
	wire d_nop    = is_misc & (op_lo == `NCE_M_NOP);
	wire d_clrc   = is_misc & (op_lo == `NCE_M_CLR_CARRY);
	wire d_set_carry_op   = is_misc & (op_lo == `NCE_M_SET_CARRY);
	wire d_acc_increment_op   = is_misc & (op_lo == `NCE_M_INC_ACC);
	wire d_acc_decrement_op   = is_misc & (op_lo == `NCE_M_DEC_ACC);
	wire d_skip_if_carry_clear   = is_misc & (op_lo == `NCE_M_SKIP_NC);
	wire d_skip_if_zero_flag_clear   = is_misc & (op_lo == `NCE_M_SKIP_NZ);
	wire d_clksel = is_misc & (op_lo == `NCE_M_CLK_SEL);
	wire d_load_carrier_timer   = is_misc & (op_lo == `NCE_M_TMR_LOAD);
	wire d_read_carrier_timer   = is_misc & (op_lo == `NCE_M_TMR_READ);
	wire d_interrupt_return_op   = is_misc & (op_lo == `NCE_M_INT_RET);
	wire d_pc_readback_op   = is_misc & (op_lo == `NCE_M_PC_READ);
	wire d_halt   = is_misc & (op_lo == `NCE_M_HALT);
	wire d_indirect_jump_op   = is_misc & (op_lo == `NCE_M_IND_JMP);
	wire d_rom_table_read   = is_misc & (op_lo[`NCE_LO_HI:1] == `NCE_M_TBL_READ);
	// a skipped two-word opcode must lose its operand word too
	wire two_word = d_jmp | d_call | d_interrupt_return_op; // RULE24
	wire skip_hit = (d_skip_if_acc_equals_mem & (acc == ram_data_i))   // RULE6
		| (d_skip_if_mem_zero & (ram_data_i == 4'h0))            // RULE7
		| (d_skip_if_acc_equals_literal & (acc == op_lo))                  // RULE8
		| (d_skip_if_carry_clear & ~carry)                          // RULE9
		| (d_skip_if_zero_flag_clear & ~zero);                          // RULE10
	wire [4:0] inc_sum = {1'b0, acc} + `NCE_INC_STEP; // RULE4
	wire [4:0] dec_sum = {1'b0, acc} + `NCE_DEC_STEP; // RULE5
	wire [3:0] hold_cls = hold[`NCE_CLS_HI:`NCE_CLS_LO];
	wire [3:0] hold_lo  = hold[`NCE_LO_HI:0];
	wire h_call  = hold_cls == `NCE_CLS_CALL;
	wire h_interrupt_return_op  = (hold_cls == `NCE_CLS_MISC) & (hold_lo == `NCE_M_INT_RET);
	wire h_indirect_jump_op  = (hold_cls == `NCE_CLS_MISC) & (hold_lo == `NCE_M_IND_JMP);
	wire int_take = (state == ST_EXEC) & ~skip_pending & int_en & int_req_i & ~in_isr;
	wire exec_go  = (state == ST_EXEC) & ~skip_pending & ~int_take;
	// memory addresses come straight from the word so compares fit one cycle
	assign ram_addr_o     = instr[`NCE_MEM_HI:0];
	assign sysreg_raddr_o = op_lo;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_state    = state;
		next_pc       = pc;
		next_acc      = acc;
		next_carry    = carry;
		next_zero     = zero;
		next_page     = page;
		next_ptr      = ptr;
		next_rom_high = rom_high;
		next_rom_top  = rom_top;
		next_clk_sel  = clk_sel;
		next_timer    = timer;
		next_timer.load = 1'b0;
		next_sysw     = '0;
		next_hold     = hold;
		next_skip     = skip_pending;
		next_in_isr   = in_isr;
		next_save     = save;
		next_run      = clock_run;
		unique case (state)
			ST_EXEC: begin
				if (skip_pending) begin
					next_skip = 1'b0;
					next_pc   = nce_inc(pc);
					if (two_word) begin
						next_state = ST_SKIP2; // RULE8
					end
				end else if (int_take) begin
					next_save   = '{pc, acc, page, carry, zero};
					next_pc     = `NCE_INT_VECTOR;
					next_in_isr = 1'b1;
				end else begin
					next_pc   = nce_inc(pc); // RULE21
					next_hold = instr;
					if (d_copy_acc_to_sysreg) begin
						next_sysw = '{1'b1, op_lo, acc}; // RULE1
						if (op_lo == `NCE_SYSREG_PAGE) begin
							next_page = acc[0];
						end
					end
					if (d_copy_sysreg_to_acc) begin
						next_acc  = sysreg_rdata_i; // RULE2
						next_zero = sysreg_rdata_i == 4'h0;
					end
					if (d_clrc | d_set_carry_op) begin
						next_carry = d_set_carry_op; // RULE3
					end
					if (d_acc_increment_op) begin
						{next_carry, next_acc} = inc_sum; // RULE4 RULE22
						next_zero = inc_sum[3:0] == 4'h0;
					end
					if (d_acc_decrement_op) begin
						{next_carry, next_acc} = dec_sum; // RULE5
						next_zero = dec_sum[3:0] == 4'h0;
					end
					next_skip = skip_hit;
					if (d_clksel) begin
						next_clk_sel = acc[1:0]; // RULE11 RULE23
					end
					if (d_load_carrier_timer) begin
						next_timer = '{1'b1, ptr[7:0]}; // RULE12
					end
					if (d_read_carrier_timer) begin
						next_ptr[7:0] = timer_count_i; // RULE13
					end
					if (d_rom_table_read) begin
						next_state = ST_TBL_RD; // RULE16
					end
					if (two_word) begin
						next_state = ST_WORD2; // RULE14
					end
					if (d_indirect_jump_op | d_pc_readback_op) begin
						next_state = ST_XTRA;
					end
					if (d_pc_readback_op) begin
						next_ptr = nce_inc(pc); // RULE18
					end
					if (d_halt) begin
						next_state = ST_HALT; // RULE19
						next_run   = 1'b0;
					end
				end
			end
			ST_WORD2: begin
				next_state = ST_EXEC;
				if (h_interrupt_return_op) begin
					next_pc     = save.pc; // RULE17
					next_acc    = save.acc;
					next_page   = save.page;
					next_carry  = save.carry;
					next_zero   = save.zero;
					next_in_isr = 1'b0;
				end else begin
					next_pc = instr; // RULE14
					if (h_call) begin
						next_ptr = nce_inc(pc); // RULE15
					end
				end
			end
			ST_TBL_RD: begin
				next_state    = ST_TBL_END;
				next_acc      = instr[3:0]; // RULE16
				next_rom_high = instr[7:4];
				next_rom_top  = instr[9:8];
			end
			ST_TBL_END: begin
				next_state = ST_EXEC;
				if (hold[0]) begin
					next_ptr = nce_inc(ptr); // RULE16
				end
			end
			ST_XTRA: begin
				next_state = ST_EXEC;
				if (h_indirect_jump_op) begin
					next_pc = ptr; // RULE20
				end
			end
			ST_HALT: begin
				// the executor itself keeps its clock so it can see the wake
				if (wake_sync | apb_wake) begin
					next_state = ST_EXEC; // RULE25
					next_run   = 1'b1;
				end
			end
			ST_SKIP2: begin
				next_state = ST_EXEC;
				next_pc    = nce_inc(pc);
			end
		endcase
	end
	assign next_rom_addr = (next_state == ST_TBL_RD) ? ptr : next_pc;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state <= ST_EXEC;
			pc <= `NCE_RESET_PC;
			rom_addr <= `NCE_RESET_PC;
			acc <= 4'h0;
			carry <= 1'b0;
			zero <= 1'b0;
			page <= 1'b0;
			ptr <= 10'h000;
			rom_high <= 4'h0;
			rom_top <= 2'h0;
			clk_sel <= 2'h0;
			timer <= '0;
			sysw <= '0;
			hold <= 10'h000;
			skip_pending <= 1'b0;
			in_isr <= 1'b0;
			save <= '0;
			clock_run <= 1'b1;
		end else begin
			state <= next_state;
			pc <= next_pc;
			rom_addr <= next_rom_addr;
			acc <= next_acc;
			carry <= next_carry;
			zero <= next_zero;
			page <= next_page;
			ptr <= next_ptr;
			rom_high <= next_rom_high;
			rom_top <= next_rom_top;
			clk_sel <= next_clk_sel;
			timer <= next_timer;
			sysw <= next_sysw;
			hold <= next_hold;
			skip_pending <= next_skip;
			in_isr <= next_in_isr;
			save <= next_save;
			clock_run <= next_run;
		end
	end

	// ------------------------------------------------------------
	// wake synchroniser and apb slave
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			wake_meta <= 1'b0;
			wake_sync <= 1'b0;
		end else begin
			wake_meta <= wake_i;
			wake_sync <= wake_meta;
		end
	end

	wire apb_setup = psel_i & ~penable_i;
	wire apb_wr    = psel_i & penable_i & pready_o & pwrite_i;
	wire hit_ctrl  = paddr_i == `NCE_APB_CTRL;
	wire hit_stat  = paddr_i == `NCE_APB_STATUS;
	wire hit_ptr   = paddr_i == `NCE_APB_POINTER;
	wire apb_map   = hit_ctrl | hit_stat | hit_ptr;
	nce_ctrl_t   ctrl_rd;
	nce_status_t stat_rd;
	nce_ptr_rd_t ptr_rd;
	nce_ctrl_t   ctrl_wr;
	assign ctrl_rd = '{30'h0, 1'b0, int_en};
	assign stat_rd = '{14'h0, in_isr, state == ST_HALT, zero, carry, acc, pc};
	assign ptr_rd  = '{16'h0, rom_top, rom_high, ptr};
	assign ctrl_wr = pwdata_i;
	wire [31:0] apb_rd = hit_ctrl ? ctrl_rd : hit_stat ? stat_rd : hit_ptr ? ptr_rd : 32'h0;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0;
			pslverr_o <= 1'b0;
			int_en    <= 1'b0;
			apb_wake  <= 1'b0;
		end else begin
			pready_o  <= apb_setup;
			pslverr_o <= apb_setup & ~apb_map;
			if (apb_setup) begin
				prdata_o <= pwrite_i ? 32'h0 : apb_rd;
			end
			if (apb_wr & hit_ctrl) begin
				int_en <= ctrl_wr.int_en;
			end
			apb_wake <= apb_wr & hit_ctrl & ctrl_wr.wake;
		end
	end

	assign rom_addr_o  = rom_addr;
	assign sysw_o      = sysw;
	assign timer_o     = timer;
	assign clk_sel_o   = clk_sel;
	assign clock_run_o = clock_run;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	property p_copy_acc_to_sysreg; exec_go & d_copy_acc_to_sysreg |=> sysw.we && sysw.data == $past(acc); endproperty
	a_copy_acc_to_sysreg: assert property (p_copy_acc_to_sysreg) else $error("acc to sysreg missing"); // RULE1
	property p_copy_sysreg_to_acc;
		exec_go & d_copy_sysreg_to_acc |=> acc == $past(sysreg_rdata_i) && zero == (acc == 4'h0)
			&& carry == $past(carry);
	endproperty
	a_copy_sysreg_to_acc: assert property (p_copy_sysreg_to_acc) else $error("sysreg to acc wrong"); // RULE2
	property p_carry; exec_go & (d_clrc | d_set_carry_op) |=> carry == $past(d_set_carry_op); endproperty
	a_carry: assert property (p_carry) else $error("carry force wrong"); // RULE3
	property p_inc; exec_go & d_acc_increment_op |=> acc == 4'($past(acc) + 4'h1) && zero == (acc == 4'h0); endproperty
	a_inc: assert property (p_inc) else $error("increment wrong"); // RULE4
	property p_dec; exec_go & d_acc_decrement_op |=> carry == ($past(acc) != 4'h0); endproperty
	a_dec: assert property (p_dec) else $error("decrement carry wrong"); // RULE5
	property p_skip; exec_go & d_skip_if_acc_equals_mem |=> skip_pending == $past(acc == ram_data_i); endproperty
	a_skip: assert property (p_skip) else $error("ram compare skip wrong"); // RULE6
	property p_skip2; skip_pending & (state == ST_EXEC) & two_word |=> state == ST_SKIP2 ##1 state == ST_EXEC; endproperty
	a_skip2: assert property (p_skip2) else $error("two-word skip wrong"); // RULE8
	property p_skipc; exec_go & d_skip_if_carry_clear |=> skip_pending == !$past(carry) && $stable(carry); endproperty
	a_skipc: assert property (p_skipc) else $error("carry skip wrong"); // RULE9
	property p_tsel; exec_go & d_clksel |=> clk_sel_o == $past(acc[1:0]); endproperty
	a_tsel: assert property (p_tsel) else $error("clock select wrong"); // RULE11
	property p_tld; exec_go & d_load_carrier_timer |=> timer_o.load && timer_o.count == $past(ptr[7:0]); endproperty
	a_tld: assert property (p_tld) else $error("timer load wrong"); // RULE12
	property p_tbl; exec_go & d_rom_table_read |=> state == ST_TBL_RD ##1 state == ST_TBL_END ##1 state == ST_EXEC; endproperty
	a_tbl: assert property (p_tbl) else $error("table read length wrong"); // RULE16
	property p_halt; exec_go & d_halt |=> !clock_run_o ##1 state == ST_HALT; endproperty
	a_halt: assert property (p_halt) else $error("halt did not stop clock"); // RULE19
	property p_stay; (state == ST_HALT) & !wake_sync & !apb_wake |=> state == ST_HALT; endproperty
	a_stay: assert property (p_stay) else $error("left halt without wake"); // RULE25
	property p_nop; exec_go & d_nop |=> $stable(acc) && $stable(ptr) && pc == nce_inc($past(pc)); endproperty
	a_nop: assert property (p_nop) else $error("no-op changed state"); // RULE21
	c_tbl: cover property (p_tbl);
	c_skip: cover property (exec_go & skip_hit ##1 two_word & skip_pending);
	c_interrupt_return_op: cover property ((state == ST_WORD2) & h_interrupt_return_op);
	c_wake: cover property ((state == ST_HALT) ##1 (state == ST_EXEC));
endmodule // nce_core
`default_nettype wire

// ===== nce_mem_model.sv
// program rom, ram, system registers and carrier timer seen by the executor
`timescale 1ns/1ns
`default_nettype none
module nce_mem_model (
	// clock
	input  wire logic                clock_i,
	// same-cycle read ports
	input  wire logic [9:0]          rom_addr_i,
	output logic [9:0]               rom_data_o,
	input  wire logic [5:0]          ram_addr_i,
	output logic [3:0]               ram_data_o,
	input  wire logic [3:0]          sysreg_raddr_i,
	output logic [3:0]               sysreg_rdata_o,
	// writes from the core
	input  wire nce_pkg::nce_sysw_t  sysw_i,
	input  wire nce_pkg::nce_timer_t timer_i,
	output logic [7:0]               timer_count_o
);
	import nce_pkg::*;
	// ------------------------------------------------------------
	// storage; rom, ram and system registers preloaded by the bench, timer set by loads
	// ------------------------------------------------------------
	logic [9:0] rom [1024];
	logic [3:0] ram [64];
	logic [3:0] sysreg [16];
	logic [7:0] tmr;
	assign rom_data_o     = rom[rom_addr_i];
	assign ram_data_o     = ram[ram_addr_i];
	assign sysreg_rdata_o = sysreg[sysreg_raddr_i];
	assign timer_count_o  = tmr;
	// the real counter runs on after a load, so readback never echoes the load
	always @(posedge clock_i) begin
		if (sysw_i.we) begin
			sysreg[sysw_i.addr] <= sysw_i.data;
		end
		if (timer_i.load) begin
			tmr <= timer_i.count ^ 8'hA5;
		end
	end
endmodule // nce_mem_model
`default_nettype wire

// ===== nce_tb.sv
// self-checking bench for the nibble core executor
`timescale 1ns/1ns
`default_nettype none
module tb;
	import nce_pkg::*;
	// ------------------------------------------------------------
	// opcodes, status holds {in_isr, halted, zero, carry, acc}
	// ------------------------------------------------------------
	localparam logic [9:0] OP_NOP = 10'h000, OP_CCLR = 10'h001, OP_CSET = 10'h002;
	localparam logic [9:0] OP_INC = 10'h003, OP_DEC = 10'h004, OP_SKNC = 10'h005;
	localparam logic [9:0] OP_SKNZ = 10'h006, OP_CKSEL = 10'h007, OP_TLOAD = 10'h008;
	localparam logic [9:0] OP_TREAD = 10'h009, OP_IRTN = 10'h00A, OP_PCRD = 10'h00B;
	localparam logic [9:0] OP_HALT = 10'h00C, OP_IJMP = 10'h00D, OP_TBL1 = 10'h00F;
	localparam logic [9:0] OP_JUMP = 10'h180, OP_CALL = 10'h1C0;
	logic        clock_i   = 1'b0;
	logic        reset_i   = 1'b1;
	logic        int_req_i = 1'b0;
	logic        wake_i    = 1'b0;
	logic        psel_i    = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i  = 1'b0;
	logic [11:0] paddr_i   = 12'h000;
	logic [31:0] pwdata_i  = 32'h00000000;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        clock_run_o;
	logic [1:0]  clk_sel_o;
	nce_sysw_t   sysw;
	nce_timer_t  timer;
	logic [9:0]  rom_addr;
	logic [9:0]  rom_data;
	logic [5:0]  ram_addr;
	logic [3:0]  ram_data;
	logic [3:0]  sr_addr;
	logic [3:0]  sr_data;
	logic [7:0]  tmr_count;
	logic [31:0] rd;
	logic        err;
	int          n_errors = 0;
	int          n_tests  = 0;
	always #10 clock_i = ~clock_i;
	nce_core nce_core_inst (.clock_i(clock_i), .reset_i(reset_i), .rom_addr_o(rom_addr),
		.rom_data_i(rom_data), .ram_addr_o(ram_addr), .ram_data_i(ram_data),
		.sysreg_raddr_o(sr_addr), .sysreg_rdata_i(sr_data), .sysw_o(sysw), .timer_o(timer),
		.clk_sel_o(clk_sel_o), .timer_count_i(tmr_count), .int_req_i(int_req_i),
		.wake_i(wake_i), .clock_run_o(clock_run_o), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o));
	nce_mem_model nce_mem_model_inst (.clock_i(clock_i), .rom_addr_i(rom_addr),
		.rom_data_o(rom_data), .ram_addr_i(ram_addr), .ram_data_o(ram_data),
		.sysreg_raddr_i(sr_addr), .sysreg_rdata_o(sr_data), .sysw_i(sysw), .timer_i(timer),
		.timer_count_o(tmr_count));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic summarize();
		if (n_errors == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int i;
		@(posedge clock_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge clock_i);
		penable_i <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clock_i);
			if (pready_o === 1'b1)
				break;
		end
		if (i == 20) begin
			n_errors++;
			summarize();
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wait_clk(input logic lvl);
		int i;
		for (i = 0; i < 300; i++) begin
			@(posedge clock_i);
			if (clock_run_o === lvl)
				break;
		end
		if (i == 300) begin
			n_errors++;
			summarize();
		end
	endtask
	task automatic st(input logic [7:0] exp);
		apb(1'b0, 12'h004, 32'h00000000);
		check(rd[17:10], exp);
	endtask
	// memories are refilled under reset so each program starts clean
	task automatic run(input logic [9:0] p[$]);
		reset_i <= 1'b1;
		for (int i = 0; i < 1024; i++) begin
			nce_mem_model_inst.rom[i] = (i < p.size()) ? p[i] : OP_NOP;
		end
		for (int i = 0; i < 64; i++) begin
			nce_mem_model_inst.ram[i] = 4'h3;
		end
		for (int i = 0; i < 16; i++) begin
			nce_mem_model_inst.sysreg[i] = 4'hA;
		end
		nce_mem_model_inst.ram[5] = 4'h0;
		nce_mem_model_inst.ram[6] = 4'h1;
		nce_mem_model_inst.sysreg[4] = 4'h0;
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
	endtask
	task automatic go(input logic [9:0] p[$], input logic [7:0] exp);
		run(p);
		wait_clk(1'b0);
		st(exp);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_alu();
		go('{OP_DEC, OP_HALT}, 8'h4F);
		go('{OP_DEC, OP_INC, OP_HALT}, 8'h70);
		go('{OP_INC, OP_DEC, OP_HALT}, 8'h70);
		go('{OP_CSET, OP_NOP, OP_HALT}, 8'h50);
		go('{OP_CSET, OP_CCLR, OP_HALT}, 8'h40);
		go('{OP_CSET, 10'h083, OP_HALT}, 8'h5A);
		go('{OP_INC, 10'h084, OP_HALT}, 8'h60);
		go('{OP_INC, OP_CSET, 10'h042, OP_HALT}, 8'h51);
		check(nce_mem_model_inst.sysreg[2], 4'h1);
	endtask
	task automatic t_skip();
		go('{10'h0C0, OP_INC, OP_HALT}, 8'h40);
		go('{10'h0C1, OP_INC, OP_HALT}, 8'h41);
		go('{10'h0C0, OP_JUMP, 10'h004, OP_INC, OP_HALT}, 8'h41);
		go('{OP_JUMP, 10'h003, OP_INC, OP_HALT}, 8'h40);
		go('{10'h145, OP_INC, 10'h107, OP_INC, 10'h106, OP_INC, OP_HALT}, 8'h41);
		go('{OP_SKNC, OP_INC, OP_SKNZ, OP_INC, OP_CSET, OP_SKNC, OP_INC, OP_DEC, OP_SKNZ,
			OP_INC, OP_HALT}, 8'h41);
	endtask
	// the timer takes its load one edge after the pulse, so the readback waits a cycle
	task automatic t_timer();
		go('{OP_INC, OP_INC, OP_INC, OP_CKSEL, OP_PCRD, OP_TLOAD, OP_NOP, OP_TREAD, OP_HALT},
			8'h43);
		check(clk_sel_o, 2'h3);
		check(timer.count, 8'h05);
		apb(1'b0, 12'h008, 32'h00000000);
		check(rd[9:0], 10'h0A0);
	endtask
	task automatic t_call();
		go('{OP_CALL, 10'h005, 10'h2D7, OP_INC, OP_HALT, OP_TBL1, OP_IJMP}, 8'h48);
		apb(1'b0, 12'h008, 32'h00000000);
		check(rd, 32'h0000B403);
		apb(1'b0, 12'h00C, 32'h00000000);
		check(err, 1'b1);
		check(rd, 32'h00000000);
		go('{10'h00E, OP_HALT}, 8'h4E);
		apb(1'b0, 12'h008, 32'h00000000);
		check(rd, 32'h00000000);
	endtask
	task automatic t_int();
		run('{OP_INC, OP_CSET, OP_JUMP, 10'h002, OP_DEC, 10'h043, OP_IRTN, OP_NOP});
		apb(1'b1, 12'h000, 32'h00000001);
		int_req_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		int_req_i <= 1'b0;
		repeat (20) @(posedge clock_i);
		st(8'h11);
		check(nce_mem_model_inst.sysreg[3], 4'h0);
	endtask
	// nops after the first halt let the wake synchroniser drain before the next halt
	task automatic t_halt();
		run('{OP_HALT, OP_NOP, OP_NOP, OP_NOP, OP_NOP, OP_INC, OP_HALT, OP_NOP, OP_INC, OP_HALT});
		wait_clk(1'b0);
		st(8'h40);
		wake_i <= 1'b1;
		wait_clk(1'b1);
		wake_i <= 1'b0;
		wait_clk(1'b0);
		st(8'h41);
		apb(1'b1, 12'h000, 32'h00000002);
		wait_clk(1'b1);
		wait_clk(1'b0);
		st(8'h42);
	endtask
	initial begin
		repeat (12) @(posedge clock_i);
		t_alu();
		t_skip();
		t_timer();
		t_call();
		t_int();
		t_halt();
		summarize();
	end
endmodule // tb
`default_nettype wire
